// *** rtl/ppc_pkg.sv ***
package ppc_pkg;
	// register-file addresses, set 1 bank 1
	localparam logic [7:0] PPC_ADDR_P1_CTRL_HIGH = 8'he5;
	localparam logic [7:0] PPC_ADDR_P1_CTRL_LOW = 8'he6;
	localparam logic [7:0] PPC_ADDR_P1_PULLUP = 8'he7;
	localparam logic [7:0] PPC_ADDR_P2_CTRL_HIGH = 8'he8;
	localparam logic [7:0] PPC_ADDR_P2_CTRL_LOW = 8'he9;
	// implemented-bit masks
	localparam logic [7:0] PPC_MASK_P1_CTRL_HIGH = 8'h3f;
	localparam logic [7:0] PPC_MASK_P1_PULLUP = 8'h7f;
	localparam logic [7:0] PPC_RESET_VALUE = 8'h00;
	// two-bit mode codes
	localparam logic [1:0] PPC_CODE_INPUT = 2'h0;
	localparam logic [1:0] PPC_CODE_P1_OPEN_DRAIN = 2'h1;
	localparam logic [1:0] PPC_CODE_P2_INPUT_PULLUP = 2'h1;
	localparam logic [1:0] PPC_CODE_PUSH_PULL = 2'h2;
	localparam logic [1:0] PPC_CODE_ALT = 2'h3;
	// port 1 pin numbers of the peripheral signals
	localparam int PPC_PIN_CAPTURE = 0;
	localparam int PPC_PIN_T1_CLOCK = 1;
	localparam int PPC_PIN_T1_OUT = 2;
	localparam int PPC_PIN_BUZZER = 3;
	localparam int PPC_PIN_SER_DOUT = 4;
	localparam int PPC_PIN_SER_CLOCK = 5;
	localparam int PPC_PIN_SER_DIN = 6;
	localparam int PPC_P1_PINS = 7;
	localparam int PPC_P2_PINS = 8;
endpackage

// *** rtl/ppc_port_config.sv ***
`timescale 1ns/1ns
module ppc_port_config (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [ppc_pkg::PPC_P1_PINS-1:0] p1_pin_in,
	output logic [ppc_pkg::PPC_P1_PINS-1:0] p1_pin_out,
	output logic [ppc_pkg::PPC_P1_PINS-1:0] p1_pin_oe,
	output logic [ppc_pkg::PPC_P1_PINS-1:0] p1_pullup_on,
	input wire logic [ppc_pkg::PPC_P1_PINS-1:0] p1_data_out,
	output logic [ppc_pkg::PPC_P1_PINS-1:0] p1_data_in,
	input wire logic [ppc_pkg::PPC_P2_PINS-1:0] p2_pin_in,
	output logic [ppc_pkg::PPC_P2_PINS-1:0] p2_pin_out,
	output logic [ppc_pkg::PPC_P2_PINS-1:0] p2_pin_oe,
	output logic [ppc_pkg::PPC_P2_PINS-1:0] p2_pullup_on,
	input wire logic [ppc_pkg::PPC_P2_PINS-1:0] p2_data_out,
	output logic [ppc_pkg::PPC_P2_PINS-1:0] p2_data_in,
	output logic [ppc_pkg::PPC_P2_PINS-1:0] p2_analog_select,
	output logic brownout_reference_input,
	input wire logic serial_clock_output,
	input wire logic serial_data_output,
	input wire logic buzzer_output,
	input wire logic timer1_toggle_output,
	input wire logic timer1_pwm_output,
	input wire logic timer1_pwm_select,
	output logic serial_clock_input,
	output logic serial_data_input,
	output logic timer1_external_clock,
	output logic timer1_capture_input
);
	import ppc_pkg::*;

	localparam int P1 = PPC_P1_PINS;
	localparam int P2 = PPC_P2_PINS;

	typedef struct packed {
		logic [7:0] p1_ctrl_high;
		logic [7:0] p1_ctrl_low;
		logic [7:0] p1_pullup;
		logic [7:0] p2_ctrl_high;
		logic [7:0] p2_ctrl_low;
		logic [P1-1:0] p1_sync1;
		logic [P1-1:0] p1_sync2;
		logic [P2-1:0] p2_sync1;
		logic [P2-1:0] p2_sync2;
		logic [7:0] rdata;
		logic [P1-1:0] p1_out;
		logic [P1-1:0] p1_oe;
		logic [P1-1:0] p1_pu;
		logic [P2-1:0] p2_out;
		logic [P2-1:0] p2_oe;
		logic [P2-1:0] p2_pu;
		logic [P2-1:0] p2_ana;
		logic bld_ref;
		logic ser_clk_in;
		logic ser_din;
		logic t1_clk;
		logic t1_cap;
	} ppc_state_t;

	ppc_state_t state_r;
	ppc_state_t state_nxt;

	// field of pin n in a 16-bit {high, low} control pair
	function automatic logic [1:0] ppc_field(input logic [15:0] pair, input int n);
		ppc_field = pair[2*n +: 2];
	endfunction

	logic [15:0] p1_pair;
	logic [15:0] p2_pair;
	logic [P1-1:0] p1_alt_val;
	logic [P1-1:0] p1_alt_ok;

	assign p1_pair = {state_r.p1_ctrl_high, state_r.p1_ctrl_low};
	assign p2_pair = {state_r.p2_ctrl_high, state_r.p2_ctrl_low};

	////////////////////////////////////////////////////////////////
	always_comb begin
		p1_alt_val = '0;
		p1_alt_ok = '0;
		p1_alt_val[PPC_PIN_SER_CLOCK] = serial_clock_output;
		p1_alt_val[PPC_PIN_SER_DOUT] = serial_data_output;
		p1_alt_val[PPC_PIN_BUZZER] = buzzer_output;
		// timer output: toggle or pwm, as the timer selects
		p1_alt_val[PPC_PIN_T1_OUT] = timer1_pwm_select ? timer1_pwm_output
			: timer1_toggle_output;
		p1_alt_ok[PPC_PIN_SER_CLOCK] = 1'b1;
		p1_alt_ok[PPC_PIN_SER_DOUT] = 1'b1;
		p1_alt_ok[PPC_PIN_BUZZER] = 1'b1;
		p1_alt_ok[PPC_PIN_T1_OUT] = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt = state_r;
		// pins are asynchronous: two flops before use
		state_nxt.p1_sync1 = p1_pin_in;
		state_nxt.p1_sync2 = state_r.p1_sync1;
		state_nxt.p2_sync1 = p2_pin_in;
		state_nxt.p2_sync2 = state_r.p2_sync1;

		// cpu port is a register-addressed file access
		if (reg_write) begin
			unique case (reg_addr)
				PPC_ADDR_P1_CTRL_HIGH: state_nxt.p1_ctrl_high = reg_wdata & PPC_MASK_P1_CTRL_HIGH;
				PPC_ADDR_P1_CTRL_LOW: state_nxt.p1_ctrl_low = reg_wdata;
				PPC_ADDR_P1_PULLUP: state_nxt.p1_pullup = reg_wdata & PPC_MASK_P1_PULLUP;
				PPC_ADDR_P2_CTRL_HIGH: state_nxt.p2_ctrl_high = reg_wdata;
				PPC_ADDR_P2_CTRL_LOW: state_nxt.p2_ctrl_low = reg_wdata;
				default: ;
			endcase
		end
		unique case (reg_addr)
			PPC_ADDR_P1_CTRL_HIGH: state_nxt.rdata = state_r.p1_ctrl_high;
			PPC_ADDR_P1_CTRL_LOW: state_nxt.rdata = state_r.p1_ctrl_low;
			PPC_ADDR_P1_PULLUP: state_nxt.rdata = state_r.p1_pullup;
			PPC_ADDR_P2_CTRL_HIGH: state_nxt.rdata = state_r.p2_ctrl_high;
			PPC_ADDR_P2_CTRL_LOW: state_nxt.rdata = state_r.p2_ctrl_low;
			default: state_nxt.rdata = 8'h00;
		endcase

		for (int n = 0; n < P1; n++) begin
			unique case (ppc_field(p1_pair, n))
				PPC_CODE_INPUT: begin
					state_nxt.p1_oe[n] = 1'b0;
					state_nxt.p1_out[n] = 1'b0;
					state_nxt.p1_pu[n] = state_r.p1_pullup[n];
				end
				PPC_CODE_P1_OPEN_DRAIN: begin
					// drive low only; high is released
					state_nxt.p1_oe[n] = ~p1_data_out[n];
					state_nxt.p1_out[n] = 1'b0;
					state_nxt.p1_pu[n] = state_r.p1_pullup[n];
				end
				PPC_CODE_PUSH_PULL: begin
					state_nxt.p1_oe[n] = 1'b1;
					state_nxt.p1_out[n] = p1_data_out[n];
					state_nxt.p1_pu[n] = 1'b0;
				end
				PPC_CODE_ALT: begin
					// unused on pins 0, 1, 6: pin floats
					state_nxt.p1_oe[n] = p1_alt_ok[n];
					state_nxt.p1_out[n] = p1_alt_val[n] & p1_alt_ok[n];
					state_nxt.p1_pu[n] = 1'b0;
				end
			endcase
		end

		for (int n = 0; n < P2; n++) begin
			unique case (ppc_field(p2_pair, n))
				PPC_CODE_INPUT: begin
					state_nxt.p2_oe[n] = 1'b0;
					state_nxt.p2_out[n] = 1'b0;
					state_nxt.p2_pu[n] = 1'b0;
					state_nxt.p2_ana[n] = 1'b0;
				end
				PPC_CODE_P2_INPUT_PULLUP: begin
					state_nxt.p2_oe[n] = 1'b0;
					state_nxt.p2_out[n] = 1'b0;
					state_nxt.p2_pu[n] = 1'b1;
					state_nxt.p2_ana[n] = 1'b0;
				end
				PPC_CODE_PUSH_PULL: begin
					state_nxt.p2_oe[n] = 1'b1;
					state_nxt.p2_out[n] = p2_data_out[n];
					state_nxt.p2_pu[n] = 1'b0;
					state_nxt.p2_ana[n] = 1'b0;
				end
				PPC_CODE_ALT: begin
					state_nxt.p2_oe[n] = 1'b0;
					state_nxt.p2_out[n] = 1'b0;
					state_nxt.p2_pu[n] = 1'b0;
					state_nxt.p2_ana[n] = 1'b1;
				end
			endcase
		end
		state_nxt.bld_ref = state_nxt.p2_ana[P2-1];

		// peripheral inputs follow the pin only in input code
		state_nxt.ser_din = (ppc_field(p1_pair, PPC_PIN_SER_DIN) == PPC_CODE_INPUT)
			& state_r.p1_sync2[PPC_PIN_SER_DIN];
		state_nxt.ser_clk_in = (ppc_field(p1_pair, PPC_PIN_SER_CLOCK) == PPC_CODE_INPUT)
			& state_r.p1_sync2[PPC_PIN_SER_CLOCK];
		state_nxt.t1_clk = (ppc_field(p1_pair, PPC_PIN_T1_CLOCK) == PPC_CODE_INPUT)
			& state_r.p1_sync2[PPC_PIN_T1_CLOCK];
		state_nxt.t1_cap = (ppc_field(p1_pair, PPC_PIN_CAPTURE) == PPC_CODE_INPUT)
			& state_r.p1_sync2[PPC_PIN_CAPTURE];

		if (reset) begin
			state_nxt = '0;
			state_nxt.p1_ctrl_high = PPC_RESET_VALUE;
			state_nxt.p1_ctrl_low = PPC_RESET_VALUE;
			state_nxt.p1_pullup = PPC_RESET_VALUE;
			state_nxt.p2_ctrl_high = PPC_RESET_VALUE;
			state_nxt.p2_ctrl_low = PPC_RESET_VALUE;
		end
	end

	always_ff @(posedge clk) begin
		state_r <= state_nxt;
	end

	////////////////////////////////////////////////////////////////
	assign reg_rdata = state_r.rdata;
	assign p1_pin_out = state_r.p1_out;
	assign p1_pin_oe = state_r.p1_oe;
	assign p1_pullup_on = state_r.p1_pu;
	assign p1_data_in = state_r.p1_sync2;
	assign p2_pin_out = state_r.p2_out;
	assign p2_pin_oe = state_r.p2_oe;
	assign p2_pullup_on = state_r.p2_pu;
	assign p2_data_in = state_r.p2_sync2;
	assign p2_analog_select = state_r.p2_ana;
	assign brownout_reference_input = state_r.bld_ref;
	assign serial_clock_input = state_r.ser_clk_in;
	assign serial_data_input = state_r.ser_din;
	assign timer1_external_clock = state_r.t1_clk;
	assign timer1_capture_input = state_r.t1_cap;
endmodule

// *** test/ppc_monitor.sv ***
`timescale 1ns/1ns
module ppc_monitor import ppc_pkg::*; (
	input logic clk,
	input logic reset,
	input logic [7:0] reg_addr,
	input logic reg_write,
	input logic [7:0] reg_wdata,
	input logic [7:0] reg_rdata,
	input logic [6:0] p1_pin_out,
	input logic [6:0] p1_pin_oe,
	input logic [6:0] p1_pullup_on,
	input logic [6:0] p1_data_in,
	input logic [7:0] p2_pin_oe,
	input logic [7:0] p2_pullup_on,
	input logic [7:0] p2_analog_select,
	input logic brownout_reference_input,
	input logic serial_data_input
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_reset_idle: assert property ($past(reset) |->
		(p1_pin_oe | p1_pullup_on) == 7'h00 && p2_pin_oe == 8'h00) else $error("pins not idle");
	a_high_mask: assert property (reg_addr == PPC_ADDR_P1_CTRL_HIGH |=>
		reg_rdata[7:6] == 2'h0) else $error("missing bits read set");
	a_write_back: assert property (reg_write && reg_addr == PPC_ADDR_P1_CTRL_LOW
		##1 !reg_write && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("write not read back");
	a_pull_drive: assert property ((p1_pin_oe & p1_pin_out & p1_pullup_on) == 7'h00)
		else $error("pullup on while driving");
	a_p2_excl: assert property ((p2_pin_oe & p2_pullup_on) == 8'h00)
		else $error("port 2 pull and drive");
	a_p2_analog: assert property ((p2_analog_select & (p2_pin_oe | p2_pullup_on)) == 8'h00)
		else $error("analog pin not released");
	a_bor_follow: assert property (brownout_reference_input == p2_analog_select[7])
		else $error("reference select mismatch");
	a_sin_follow: assert property (serial_data_input |-> $past(p1_data_in[6]))
		else $error("serial input without pad");
endmodule

// *** test/ppc_board.sv ***
`timescale 1ns/1ns
module ppc_board #(parameter int W = 7) (
	input logic clk,
	input logic [W-1:0] pin_out,
	input logic [W-1:0] pin_oe,
	input logic [W-1:0] pull_on,
	input logic [W-1:0] ext,
	input logic [W-1:0] ext_en,
	output logic [W-1:0] pin_in
);
	logic float_r = 1'b0;
	// a floating pad wanders, so it never reads as a steady level
	always_ff @(posedge clk) float_r <= ~float_r;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext)
		| (~pin_oe & ~ext_en & (pull_on | {W{float_r}}));
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t: %h / %h", $time, a, b); end end
module tb_top;
	import ppc_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_write = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [6:0] p1_data_out = 7'h7f;
	logic [7:0] p2_data_out = 8'hff;
	logic buzzer_output = 1'b1;
	logic serial_clock_output = 1'b1;
	logic serial_data_output = 1'b0;
	logic timer1_toggle_output = 1'b0;
	logic timer1_pwm_output = 1'b0;
	logic timer1_pwm_select = 1'b0;
	logic [6:0] ext1 = 7'h00;
	logic [6:0] ext1_en = 7'h00;
	logic [7:0] ext2 = 8'h00;
	logic [7:0] ext2_en = 8'h00;
	logic [7:0] reg_rdata, p2_pin_in, p2_pin_out, p2_pin_oe, p2_pullup_on, p2_data_in;
	logic [7:0] p2_analog_select;
	logic [6:0] p1_pin_in, p1_pin_out, p1_pin_oe, p1_pullup_on, p1_data_in;
	logic brownout_reference_input, serial_clock_input, serial_data_input;
	logic timer1_external_clock, timer1_capture_input;
	int errors = 0;
	int n_compared = 0;
	ppc_port_config i_dut (.*);
	ppc_board #(.W(7)) i_b1 (.clk, .pin_out(p1_pin_out), .pin_oe(p1_pin_oe),
		.pull_on(p1_pullup_on), .ext(ext1), .ext_en(ext1_en), .pin_in(p1_pin_in));
	ppc_board #(.W(8)) i_b2 (.clk, .pin_out(p2_pin_out), .pin_oe(p2_pin_oe),
		.pull_on(p2_pullup_on), .ext(ext2), .ext_en(ext2_en), .pin_in(p2_pin_in));
	initial forever #4 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_write <= 1'b1;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		repeat (2) @(posedge clk);
		#1 `CHK(reg_rdata, e)
	endtask
	task settle;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task t_regs;
		for (int a = 8'he4; a <= 8'he9; a++) rd(a[7:0], 8'h00);
		wr(PPC_ADDR_P1_CTRL_HIGH, 8'hff);
		rd(PPC_ADDR_P1_CTRL_HIGH, 8'h3f);
		wr(PPC_ADDR_P1_PULLUP, 8'hff);
		rd(PPC_ADDR_P1_PULLUP, 8'h7f);
	endtask
	task t_p1;
		logic [3:0] oe_t = 4'b1100;
		logic [3:0] out_t = 4'b1100;
		logic [3:0] pu_t = 4'b0011;
		for (int c = 0; c < 4; c++) begin
			wr(PPC_ADDR_P1_CTRL_LOW, 8'(c << 6));
			settle;
			`CHK({p1_pin_oe[3], p1_pin_out[3], p1_pullup_on[3]}, {oe_t[c], out_t[c], pu_t[c]})
		end
		wr(PPC_ADDR_P1_CTRL_HIGH, 8'h0c);
		settle;
		`CHK({p1_pin_oe[5], p1_pin_out[5], p1_pullup_on[5]}, 3'h6)
		wr(PPC_ADDR_P1_CTRL_LOW, 8'h40);
		p1_data_out <= 7'h77;
		settle;
		`CHK({p1_pin_oe[3], p1_pin_out[3], p1_pullup_on[3]}, 3'h5)
		wr(PPC_ADDR_P1_CTRL_HIGH, 8'h33);
		wr(PPC_ADDR_P1_CTRL_LOW, 8'h3f);
		serial_data_output <= 1'b1;
		timer1_pwm_output <= 1'b1;
		timer1_pwm_select <= 1'b1;
		settle;
		`CHK(p1_pin_oe, 7'h14)
		`CHK(p1_pin_out, 7'h14)
		`CHK(p1_pullup_on, 7'h28)
		@(posedge clk);
		timer1_pwm_select <= 1'b0;
		settle;
		`CHK(p1_pin_out, 7'h10)
	endtask
	task t_in;
		wr(PPC_ADDR_P1_CTRL_HIGH, 8'h00);
		wr(PPC_ADDR_P1_CTRL_LOW, 8'h00);
		ext1_en <= 7'h63;
		ext1 <= 7'h63;
		settle;
		`CHK({serial_data_input, serial_clock_input}, 2'h3)
		`CHK({timer1_external_clock, timer1_capture_input}, 2'h3)
		`CHK(p1_data_in, 7'h7f)
		wr(PPC_ADDR_P1_CTRL_LOW, 8'h05);
		settle;
		`CHK({timer1_external_clock, timer1_capture_input}, 2'h0)
	endtask
	task t_p2;
		logic [3:0] oe_t = 4'b0100;
		logic [3:0] pu_t = 4'b0010;
		logic [3:0] an_t = 4'b1000;
		@(posedge clk);
		ext2_en <= 8'h0f;
		ext2 <= 8'h05;
		for (int c = 0; c < 4; c++) begin
			wr(PPC_ADDR_P2_CTRL_LOW, {4{c[1:0]}});
			wr(PPC_ADDR_P2_CTRL_HIGH, {4{c[1:0]}});
			settle;
			`CHK({p2_pin_oe[0], p2_pullup_on[0], p2_pin_out[0]}, {oe_t[c], pu_t[c], oe_t[c]})
			`CHK({p2_analog_select[0], brownout_reference_input}, {2{an_t[c]}})
			`CHK(p2_data_in[3:0], oe_t[c] ? 4'hf : 4'h5)
		end
	endtask
	task t_reset;
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (int a = 8'he5; a <= 8'he9; a++) rd(a[7:0], 8'h00);
		`CHK({p1_pin_oe, p1_pullup_on, p2_pin_oe, p2_pullup_on, p2_analog_select}, 38'h0)
		`CHK(brownout_reference_input, 1'b0)
	endtask
	task stop_test;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		t_regs;
		t_p1;
		t_in;
		t_p2;
		t_reset;
		stop_test;
	end
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		stop_test;
	end
endmodule
bind ppc_port_config ppc_monitor i_mon (.*);
